// ===== hw/frg_pkg.sv
/*
  Constants and carrier types for the frequency ramp generator.
  Assumes a 10 MHz system clock; frequencies in 0.1 Hz units.
*/
package frg_pkg;
  // ***************
  // Widths and clock
  // ***************
  localparam int FW = 16;
  localparam int TW = 16;
  localparam int AW = 24;
  localparam int CW = 24;
  localparam int NUM_SETS = 4;
  localparam int NUM_BANDS = 3;
  localparam int CLK_PERIOD_NS = 100;
  localparam int UNIT_FINE_MS = 10;
  localparam int UNIT_COARSE_MS = 100;
  localparam int TICK_FINE_CYC = UNIT_FINE_MS * 1000000 / CLK_PERIOD_NS;
  localparam int TICK_COARSE_CYC = UNIT_COARSE_MS * 1000000 / CLK_PERIOD_NS;
  // ***************
  // Values after reset
  // ***************
  localparam logic [TW-1:0] INCH_TIME_DEF_FINE = 16'h03E8;
  localparam logic [TW-1:0] INCH_TIME_DEF_COARSE = 16'h0064;
  localparam logic [TW-1:0] SCURVE_DEF_FINE = 16'h0014;
  localparam logic [TW-1:0] SCURVE_DEF_COARSE = 16'h0002;
  localparam logic [FW-1:0] INCH_FREQ_DEF = 16'h003C;
  localparam logic [FW-1:0] SWITCH_FREQ_DEF = 16'h0000;
  localparam logic [TW-1:0] AUTO_RAMP_TIME_DEF = 16'h0064;
  localparam logic [1:0] SET_FIRST = 2'h0;
  localparam logic [1:0] SET_FOURTH = 2'h3;
  // ***************
  // Types
  // ***************
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0, ST_RUN = 2'h1, ST_INCH = 2'h2, ST_INCH_STOP = 2'h3
  } frg_mode_t;
  typedef enum logic [1:0] {
    ZS_WAIT = 2'h0, ZS_DC_BRAKE = 2'h1, ZS_FMIN = 2'h2
  } frg_zero_t;
  typedef enum logic [2:0] {
    AR_LINEAR = 3'h0, AR_AUTO_ACC = 3'h1, AR_AUTO_DEC = 3'h2, AR_AUTO_BOTH = 3'h3,
    AR_LINEAR_STALL = 3'h4
  } frg_auto_t;
  typedef struct packed {
    logic ramp_time_unit_select;
    frg_auto_t auto_ramp_mode;
    frg_zero_t zero_speed_mode;
    logic ramp_sel_terminal_en;
    logic canopen_control;
    logic [FW-1:0] max_output_frequency;
    logic [FW-1:0] min_frequency;
    logic [FW-1:0] inch_target_frequency;
    logic [FW-1:0] ramp_set_switch_frequency;
    logic [NUM_SETS-1:0][TW-1:0] accel_time_set;
    logic [NUM_SETS-1:0][TW-1:0] decel_time_set;
    logic [TW-1:0] scurve_accel_begin_time;
    logic [TW-1:0] scurve_accel_arrival_time;
    logic [TW-1:0] scurve_decel_begin_time;
    logic [TW-1:0] scurve_decel_arrival_time;
    logic [TW-1:0] canopen_decel_time;
    logic [TW-1:0] inch_accel_time;
    logic [TW-1:0] inch_decel_time;
    logic [NUM_BANDS-1:0][1:0][FW-1:0] skip_band_bound;
  } frg_cfg_t;
  typedef struct packed {
    logic run_cmd;
    logic inch_cmd;
    logic keypad_inch_key;
    logic [1:0] ramp_set_pins;
    logic stall_active;
  } frg_pins_t;
  typedef struct packed {
    logic [FW-1:0] out_freq;
    logic output_on;
    logic dc_brake;
    logic running;
    logic accelerating;
    logic decelerating;
    logic inch_active;
    logic [1:0] ramp_set;
  } frg_out_t;
  typedef struct packed {
    frg_mode_t mode;
    frg_pins_t meta;
    frg_pins_t sync;
    logic [FW-1:0] target;
    logic [AW-1:0] acc;
    logic [CW-1:0] tick_cnt;
    logic inch_custom;
    logic [TW-1:0] inch_accel;
    logic [TW-1:0] inch_decel;
    frg_out_t out;
  } frg_state_t;
endpackage

// ===== hw/frg_ramp_gen.sv
/*
  Output-frequency ramp generator of a motor drive: run and inch
  control, ramp set selection, skip bands, zero-speed handling.
  Assumes configuration inputs are static or on clk_sys; pins are async.
*/
module frg_ramp_gen
  import frg_pkg::*;
#(
  parameter int TICK_FINE = TICK_FINE_CYC,
  parameter int TICK_COARSE = TICK_COARSE_CYC,
  parameter logic [TW-1:0] AUTO_RAMP_TIME = AUTO_RAMP_TIME_DEF
)
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire frg_pins_t pins,
  input wire frg_cfg_t cfg,
  input wire logic [FW-1:0] freq_command,
  input wire logic inch_time_load,
  output frg_out_t status
);

  // ************************
  // Helpers
  // ************************
  function automatic logic [TW:0] eff_time(input logic [TW-1:0] t,
                                           input logic [TW-1:0] s1,
                                           input logic [TW-1:0] s2);
    logic [TW:0] half;
    half = ({1'b0, s1} + {1'b0, s2}) >> 1;
    if (t != '0 && t >= s1 && t >= s2)
    begin
      return {1'b0, t} + half;
    end
    return {1'b0, t};
  endfunction

  frg_state_t s_q;
  frg_state_t s_d;
  logic [FW-1:0] cmd;
  logic [NUM_BANDS-1:0] band_hit;
  logic [NUM_BANDS-1:0][FW-1:0] band_lo;
  logic inch_req;
  logic below_min;
  logic tick;
  logic up;
  logic down;
  logic auto_acc;
  logic auto_dec;
  logic [1:0] set;
  logic [FW-1:0] steady;
  logic [FW-1:0] tgt;
  logic [FW-1:0] span;
  logic [TW:0] rtime;
  logic [TW-1:0] inch_acc_t;
  logic [TW-1:0] inch_dec_t;
  logic [AW-1:0] acc_n;
  logic [FW-1:0] freq_n;
  logic [CW-1:0] tick_last;

  assign cmd = (freq_command > cfg.max_output_frequency) ? cfg.max_output_frequency
                                                         : freq_command;

  // ************************
  // Skip bands
  // ************************
  for (genvar b = 0; b < NUM_BANDS; b++)
  begin : g_band
    logic [FW-1:0] ba;
    logic [FW-1:0] bb;
    logic [FW-1:0] hi;
    assign ba = cfg.skip_band_bound[b][0];
    assign bb = cfg.skip_band_bound[b][1];
    assign band_lo[b] = (ba < bb) ? ba : bb;
    assign hi = (ba < bb) ? bb : ba;
    assign band_hit[b] = (ba != bb) && (cmd >= band_lo[b]) && (cmd <= hi);
  end

  // ************************
  // Next state
  // ************************
  always_comb
  begin
    s_d = s_q;
    s_d.meta = pins;
    s_d.sync = s_q.meta;
    inch_req = s_q.sync.inch_cmd | s_q.sync.keypad_inch_key;
    below_min = cmd < cfg.min_frequency;

    // Factory inch time follows the unit until software loads its own
    if (inch_time_load)
    begin
      s_d.inch_custom = 1'b1;
      s_d.inch_accel = cfg.inch_accel_time;
      s_d.inch_decel = cfg.inch_decel_time;
    end
    inch_acc_t = s_q.inch_custom ? s_q.inch_accel :
                 (cfg.ramp_time_unit_select ? INCH_TIME_DEF_COARSE : INCH_TIME_DEF_FINE);
    inch_dec_t = s_q.inch_custom ? s_q.inch_decel :
                 (cfg.ramp_time_unit_select ? INCH_TIME_DEF_COARSE : INCH_TIME_DEF_FINE);

    if (cfg.ramp_sel_terminal_en)
    begin
      set = s_q.sync.ramp_set_pins;
    end
    else if (cfg.ramp_set_switch_frequency != '0 &&
             s_q.out.out_freq >= cfg.ramp_set_switch_frequency)
    begin
      set = SET_FOURTH;
    end
    else
    begin
      set = SET_FIRST;
    end
    s_d.out.ramp_set = set;

    case (s_q.mode)
      ST_IDLE:
      begin
        if (s_q.sync.run_cmd && !inch_req)
        begin
          s_d.mode = ST_RUN;
        end
        else if (inch_req && !s_q.sync.run_cmd && s_q.out.out_freq == '0)
        begin
          s_d.mode = ST_INCH;
        end
      end
      ST_RUN:
      begin
        if (!s_q.sync.run_cmd)
        begin
          s_d.mode = ST_IDLE;
        end
      end
      ST_INCH:
      begin
        // Run command is not looked at here
        if (!inch_req)
        begin
          s_d.mode = ST_INCH_STOP;
        end
      end
      ST_INCH_STOP:
      begin
        if (s_q.out.out_freq == '0)
        begin
          s_d.mode = ST_IDLE;
        end
      end
      default:
      begin
        s_d.mode = ST_IDLE;
      end
    endcase

    steady = cmd;
    for (int i = NUM_BANDS - 1; i >= 0; i--)
    begin
      if (band_hit[i])
      begin
        steady = band_lo[i];
      end
    end

    case (s_q.mode)
      ST_RUN:
      begin
        if (below_min)
        begin
          tgt = (cfg.zero_speed_mode == ZS_FMIN) ? cfg.min_frequency : '0;
        end
        else
        begin
          tgt = steady;
        end
      end
      ST_INCH:
      begin
        tgt = cfg.inch_target_frequency;
      end
      default:
      begin
        tgt = '0;
      end
    endcase
    s_d.target = tgt;

    up = tgt > s_q.out.out_freq;
    down = tgt < s_q.out.out_freq;
    auto_acc = cfg.auto_ramp_mode == AR_AUTO_ACC || cfg.auto_ramp_mode == AR_AUTO_BOTH;
    auto_dec = cfg.auto_ramp_mode == AR_AUTO_DEC || cfg.auto_ramp_mode == AR_AUTO_BOTH;

    if (s_q.mode == ST_INCH || s_q.mode == ST_INCH_STOP)
    begin
      span = cfg.inch_target_frequency;
      rtime = up ? {1'b0, inch_acc_t} : {1'b0, inch_dec_t};
    end
    else if (up)
    begin
      span = cfg.max_output_frequency;
      rtime = auto_acc ? {1'b0, AUTO_RAMP_TIME} :
              eff_time(cfg.accel_time_set[set], cfg.scurve_accel_begin_time,
                       cfg.scurve_accel_arrival_time);
    end
    else
    begin
      span = cfg.max_output_frequency;
      if (auto_dec)
      begin
        rtime = {1'b0, AUTO_RAMP_TIME};
      end
      else if (cfg.canopen_control)
      begin
        rtime = {1'b0, cfg.canopen_decel_time};
      end
      else
      begin
        rtime = eff_time(cfg.decel_time_set[set], cfg.scurve_decel_begin_time,
                         cfg.scurve_decel_arrival_time);
      end
    end

    // Tick length carries the time unit, so time fields need no scaling
    tick_last = cfg.ramp_time_unit_select ? CW'(TICK_COARSE - 1) : CW'(TICK_FINE - 1);
    tick = s_q.tick_cnt >= tick_last;
    s_d.tick_cnt = tick ? '0 : s_q.tick_cnt + 1'b1;

    // Span-per-time accumulator; a held add stretches the ramp
    freq_n = s_q.out.out_freq;
    acc_n = s_q.acc;
    if (!up && !down)
    begin
      acc_n = '0;
    end
    else
    begin
      if (tick && !s_q.sync.stall_active)
      begin
        acc_n = acc_n + AW'(span);
      end
      if (acc_n >= AW'(rtime))
      begin
        acc_n = acc_n - AW'(rtime);
        freq_n = up ? s_q.out.out_freq + 1'b1 : s_q.out.out_freq - 1'b1;
      end
    end
    s_d.acc = acc_n;

    s_d.out.out_freq = freq_n;
    s_d.out.accelerating = up;
    s_d.out.decelerating = down;
    s_d.out.running = freq_n != '0;
    s_d.out.inch_active = s_q.mode == ST_INCH || s_q.mode == ST_INCH_STOP;
    s_d.out.dc_brake = s_q.mode == ST_RUN && below_min &&
                       cfg.zero_speed_mode == ZS_DC_BRAKE && freq_n == '0;
    s_d.out.output_on = freq_n != '0 || s_d.out.dc_brake;
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s_q <= '0;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  assign status = s_q.out;

  // ************************
  // Checks
  // ************************
  default clocking cb @(posedge clk_sys iff clk_en);
  endclocking
  default disable iff (!arst_n);

  sequence inch_release_s;
    s_q.mode == ST_INCH && !inch_req;
  endsequence

  sequence inch_stopping_s;
    s_q.mode == ST_INCH_STOP ##1 s_q.target == '0;
  endsequence

  AST_STEP_ONE: assert property (
    s_q.out.out_freq != $past(s_q.out.out_freq) |->
      (s_q.out.out_freq == $past(s_q.out.out_freq) + 16'h0001 ||
       s_q.out.out_freq == $past(s_q.out.out_freq) - 16'h0001))
    else $error("Output frequency moved by more than one step");

  AST_NO_OVERSHOOT: assert property (
    $past(s_q.out.out_freq) <= s_q.target |-> s_q.out.out_freq <= s_q.target)
    else $error("Output frequency passed the target");

  AST_SKIP_HOLD: assert property (
    s_q.mode == ST_RUN && !below_min && band_hit[0] |=> s_q.target == $past(band_lo[0]))
    else $error("Command in skip band not held at lower bound");

  AST_INCH_REJECT: assert property (
    s_q.mode == ST_IDLE && s_q.out.out_freq != '0 |=> s_q.mode != ST_INCH)
    else $error("Inch accepted while running");

  AST_INCH_LOCK: assert property (
    s_q.mode == ST_INCH |=> s_q.mode == ST_INCH || s_q.mode == ST_INCH_STOP)
    else $error("Other command taken during inch");

  AST_INCH_STOP: assert property (
    inch_release_s |=> inch_stopping_s)
    else $error("Inch release did not ramp to stop");

  AST_SET_PRIO: assert property (
    cfg.ramp_sel_terminal_en |=> s_q.out.ramp_set == $past(s_q.sync.ramp_set_pins))
    else $error("Terminal set selection not applied");

  AST_SET_SWITCH: assert property (
    !cfg.ramp_sel_terminal_en && cfg.ramp_set_switch_frequency != '0 &&
    s_q.out.out_freq >= cfg.ramp_set_switch_frequency |=> s_q.out.ramp_set == SET_FOURTH)
    else $error("Fourth set not chosen above threshold");

  AST_STALL_HOLD: assert property (
    s_q.sync.stall_active && tick |=> s_q.acc <= $past(s_q.acc))
    else $error("Ramp advanced during stall");

  AST_DC_BRAKE: assert property (
    s_q.mode == ST_RUN && below_min && cfg.zero_speed_mode == ZS_DC_BRAKE &&
    s_q.out.out_freq == '0 |=> s_q.out.dc_brake && s_q.out.output_on)
    else $error("DC brake missing below minimum");

  AST_WAIT_OFF: assert property (
    s_q.mode == ST_IDLE && s_q.out.out_freq == '0 |=> !s_q.out.output_on)
    else $error("Output on while waiting");

endmodule // frg_ramp_gen

// ===== tb/frg_motor_model.sv
/*
  Behavioural inverter stage and motor fed by the ramp generator.
  Assumes status comes registered from the generator on clk_sys.
*/
module frg_motor_model
  import frg_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire frg_out_t status,
  output logic [FW-1:0] motor_freq
);
  timeunit 1ns;
  timeprecision 1ns;
  // *****
  // Motor speed
  // *****
  // Without voltage the shaft coasts down, it does not stop at once
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      motor_freq <= '0;
    else if (status.output_on && !status.dc_brake)
      motor_freq <= status.out_freq;
    else if (motor_freq != '0)
      motor_freq <= motor_freq - 16'h0001;
  end
endmodule // frg_motor_model

// ===== tb/test_frequency_ramp_generator.sv
/*
  Self-checking bench for frg_ramp_gen beside an inverter stage model.
  Assumes ticks shortened to 4 and 40 cycles and a 10 MHz clock.
*/
module test_frequency_ramp_generator
  import frg_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys;
  logic arst_n;
  logic clk_en;
  frg_pins_t pins;
  frg_cfg_t cfg;
  logic [FW-1:0] freq_command;
  logic inch_time_load;
  frg_out_t status;
  logic [FW-1:0] motor_freq;
  int err_total = 0;
  int num_checks = 0;
  int cyc = 0;
  int n;

  frg_ramp_gen #(.TICK_FINE(4), .TICK_COARSE(40), .AUTO_RAMP_TIME(16'h001E)) frg_ramp_gen_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .pins(pins), .cfg(cfg),
    .freq_command(freq_command), .inch_time_load(inch_time_load), .status(status));
  frg_motor_model frg_motor_model_i (
    .clk_sys(clk_sys), .arst_n(arst_n), .status(status), .motor_freq(motor_freq));

  // *****
  // Checking helpers
  // *****
  task automatic miss(input string what);
    err_total++;
    $display("wrong value at %0t: %s", $time, what);
  endtask
  task automatic chk(input logic [FW-1:0] got, input logic [FW-1:0] e, input string what);
    num_checks++;
    if (got !== e)
      miss($sformatf("%s got %0d expected %0d", what, got, e));
  endtask
  task automatic rng(input int v, input int lo, input int hi, input string what);
    num_checks++;
    if (v < lo || v > hi)
      miss($sformatf("%s took %0d cycles", what, v));
  endtask
  // Also catches any jump of more than one step per cycle
  task automatic wait_freq(input logic [FW-1:0] e, input int lim);
    logic [FW-1:0] prev;
    #1;
    n = 0;
    prev = status.out_freq;
    while (status.out_freq !== e && n < lim)
    begin
      @(posedge clk_sys);
      #1;
      n++;
      if (status.out_freq > prev + 16'h0001 || prev > status.out_freq + 16'h0001)
        miss("output frequency jumped");
      prev = status.out_freq;
    end
    chk(status.out_freq, e, "settled frequency");
  endtask
  task automatic run_to(input logic [FW-1:0] cmd, input logic [FW-1:0] e, input int lim);
    @(posedge clk_sys);
    freq_command <= cmd;
    pins.run_cmd <= 1'b1;
    wait_freq(e, lim);
  endtask
  task automatic stop(input int lim);
    @(posedge clk_sys);
    pins.run_cmd <= 1'b0;
    wait_freq(16'h0000, lim);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // *****
  // Scenarios
  // *****
  task automatic t_modes();
    int e;
    logic [FW-1:0] f;
    for (int m = 0; m < 5; m++)
    begin
      @(posedge clk_sys);
      cfg.auto_ramp_mode <= frg_auto_t'(m);
      e = (m == 1 || m == 3) ? 120 : 40;
      run_to(16'h0014, 16'h0014, 400);
      rng(n, e - 4, e + 14, "accel");
      e = (m == 2 || m == 3) ? 120 : 40;
      stop(400);
      rng(n, e - 4, e + 14, "decel");
    end
    @(posedge clk_sys);
    cfg.ramp_time_unit_select <= 1'b1;
    run_to(16'h0014, 16'h0014, 600);
    // First tick may land up to one coarse tick after the run starts
    rng(n, 360, 424, "coarse accel");
    stop(600);
    @(posedge clk_sys);
    cfg.ramp_time_unit_select <= 1'b0;
    pins.stall_active <= 1'b1;
    freq_command <= 16'h0014;
    pins.run_cmd <= 1'b1;
    repeat (40) @(posedge clk_sys);
    #1;
    chk(status.out_freq, 16'h0000, "frozen by stall");
    chk(16'({status.accelerating, status.running}), 16'h0002, "flags while frozen");
    @(posedge clk_sys);
    pins.stall_active <= 1'b0;
    wait_freq(16'h0014, 100);
    @(posedge clk_sys);
    pins.run_cmd <= 1'b0;
    repeat (5) @(posedge clk_sys);
    #1;
    chk(16'({status.decelerating, status.running}), 16'h0003, "flags while stopping");
    @(posedge clk_sys);
    clk_en <= 1'b0;
    #1;
    f = status.out_freq;
    repeat (20) @(posedge clk_sys);
    #1;
    chk(status.out_freq, f, "frozen by clock enable");
    @(posedge clk_sys);
    clk_en <= 1'b1;
    wait_freq(16'h0000, 200);
    $display("modes test done");
  endtask
  task automatic t_sets();
    for (int k = 0; k < NUM_SETS; k++)
    begin
      @(posedge clk_sys);
      cfg.ramp_sel_terminal_en <= 1'b1;
      pins.ramp_set_pins <= 2'(k);
      cfg.accel_time_set[k] <= 16'(10 * (k + 1));
      run_to(16'h0014, 16'h0014, 300);
      rng(n, 40 * k + 36, 40 * k + 56, "set accel");
      chk(16'(status.ramp_set), 16'(k), "ramp set");
      stop(200);
    end
    // Set four now takes 40 units, so the threshold shows in the time
    @(posedge clk_sys);
    cfg.ramp_sel_terminal_en <= 1'b0;
    pins.ramp_set_pins <= 2'h0;
    cfg.ramp_set_switch_frequency <= 16'h000A;
    run_to(16'h0014, 16'h0014, 300);
    rng(n, 96, 126, "threshold accel");
    chk(16'(status.ramp_set), 16'(SET_FOURTH), "above threshold");
    @(posedge clk_sys);
    cfg.ramp_sel_terminal_en <= 1'b1;
    pins.ramp_set_pins <= 2'h1;
    repeat (6) @(posedge clk_sys);
    #1;
    chk(16'(status.ramp_set), 16'h0001, "terminal priority");
    stop(200);
    @(posedge clk_sys);
    cfg.ramp_sel_terminal_en <= 1'b0;
    cfg.ramp_set_switch_frequency <= 16'h0000;
    $display("sets test done");
  endtask
  task automatic t_scurve_fieldbus();
    @(posedge clk_sys);
    cfg.scurve_accel_begin_time <= 16'h0004;
    cfg.scurve_accel_arrival_time <= 16'h0004;
    cfg.scurve_decel_begin_time <= 16'h0002;
    cfg.scurve_decel_arrival_time <= 16'h0006;
    run_to(16'h0014, 16'h0014, 300);
    rng(n, 52, 72, "s-curve accel");
    stop(300);
    rng(n, 52, 72, "s-curve decel");
    @(posedge clk_sys);
    cfg.accel_time_set[0] <= 16'h0000;
    cfg.decel_time_set[0] <= 16'h0000;
    run_to(16'h0014, 16'h0014, 100);
    rng(n, 20, 30, "zero time accel");
    stop(100);
    rng(n, 20, 30, "zero time decel");
    @(posedge clk_sys);
    cfg.accel_time_set[0] <= 16'h000A;
    cfg.decel_time_set[0] <= 16'h000A;
    cfg.canopen_control <= 1'b1;
    cfg.canopen_decel_time <= 16'h0014;
    run_to(16'h0014, 16'h0014, 300);
    stop(300);
    rng(n, 76, 98, "fieldbus decel");
    @(posedge clk_sys);
    cfg.canopen_control <= 1'b0;
    $display("s-curve and fieldbus test done");
  endtask
  task automatic t_skip_zero();
    for (int b = 0; b < NUM_BANDS; b++)
    begin
      @(posedge clk_sys);
      cfg.skip_band_bound[b][0] <= (b == 1) ? 16'h0008 : 16'h000F;
      cfg.skip_band_bound[b][1] <= (b == 1) ? 16'h000F : 16'h0008;
      run_to(16'h000C, 16'h0008, 200);
      repeat (20) @(posedge clk_sys);
      #1;
      chk(status.out_freq, 16'h0008, "held at lower bound");
      chk(motor_freq, 16'h0008, "motor speed");
      @(posedge clk_sys);
      freq_command <= 16'h0014;
      wait_freq(16'h0014, 200);
      stop(200);
      @(posedge clk_sys);
      cfg.skip_band_bound[b] <= '0;
    end
    @(posedge clk_sys);
    cfg.min_frequency <= 16'h0005;
    for (int m = 0; m < 3; m++)
    begin
      @(posedge clk_sys);
      cfg.zero_speed_mode <= frg_zero_t'(m);
      run_to(16'h0003, (m == 2) ? 16'h0005 : 16'h0000, 60);
      repeat (10) @(posedge clk_sys);
      #1;
      chk(16'({status.output_on, status.dc_brake}), 16'((m == 0) ? 0 : 4 - m), "zero mode");
      stop(100);
    end
    @(posedge clk_sys);
    cfg.min_frequency <= 16'h0000;
    cfg.zero_speed_mode <= ZS_WAIT;
    $display("skip and zero speed test done");
  endtask
  task automatic t_inch();
    @(posedge clk_sys);
    pins.inch_cmd <= 1'b1;
    wait_freq(16'h0006, 4300);
    rng(n, 3990, 4040, "factory inch accel");
    chk(16'(status.inch_active), 16'h0001, "inch flag");
    @(posedge clk_sys);
    freq_command <= 16'h0014;
    pins.run_cmd <= 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    chk(status.out_freq, 16'h0006, "run during inch");
    @(posedge clk_sys);
    pins.inch_cmd <= 1'b0;
    pins.run_cmd <= 1'b0;
    wait_freq(16'h0000, 4300);
    rng(n, 3990, 4040, "factory inch decel");
    @(posedge clk_sys);
    cfg.inch_accel_time <= 16'h000A;
    cfg.inch_decel_time <= 16'h000A;
    inch_time_load <= 1'b1;
    @(posedge clk_sys);
    inch_time_load <= 1'b0;
    pins.keypad_inch_key <= 1'b1;
    wait_freq(16'h0006, 200);
    rng(n, 36, 60, "loaded inch accel");
    @(posedge clk_sys);
    pins.keypad_inch_key <= 1'b0;
    wait_freq(16'h0000, 200);
    run_to(16'h0014, 16'h0014, 200);
    @(posedge clk_sys);
    pins.inch_cmd <= 1'b1;
    repeat (10) @(posedge clk_sys);
    #1;
    chk(16'(status.inch_active), 16'h0000, "inch while running");
    @(posedge clk_sys);
    pins.inch_cmd <= 1'b0;
    stop(200);
    // Reset at standstill drops the loaded inch times
    @(posedge clk_sys);
    arst_n <= 1'b0;
    @(posedge clk_sys);
    arst_n <= 1'b1;
    pins.inch_cmd <= 1'b1;
    wait_freq(16'h0006, 4300);
    rng(n, 3990, 4040, "inch accel after reset");
    @(posedge clk_sys);
    pins.inch_cmd <= 1'b0;
    wait_freq(16'h0000, 4300);
    $display("inch test done");
  endtask

  // *****
  // Clock, watchdog and main sequence
  // *****
  initial
  begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Whole run is near 19500 cycles
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      miss("run did not finish in time");
      tally_and_finish();
    end
  end
  initial
  begin
    arst_n = 1'b0;
    clk_en = 1'b1;
    pins = '0;
    cfg = '0;
    cfg.max_output_frequency = 16'h0014;
    cfg.inch_target_frequency = 16'h0006;
    for (int k = 0; k < NUM_SETS; k++)
    begin
      cfg.accel_time_set[k] = 16'h000A;
      cfg.decel_time_set[k] = 16'h000A;
    end
    freq_command = '0;
    inch_time_load = 1'b0;
    repeat (11) @(posedge clk_sys);
    #1;
    chk(status.out_freq, 16'h0000, "reset frequency");
    chk(16'({status.output_on, status.inch_active, status.ramp_set}), 16'h0000, "reset flags");
    @(posedge clk_sys);
    arst_n <= 1'b1;
    t_modes();
    t_sets();
    t_scurve_fieldbus();
    t_skip_zero();
    t_inch();
    tally_and_finish();
  end
endmodule // test_frequency_ramp_generator
